// ===== hw/mgctl_coil.sv
module mgctl_coil (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           ctrl_wr,
  input  wire logic [7:0]                     ctrl_wdata,
  input  wire logic                           low_voltage,
  input  wire logic                           measure_complete_strobe,
  input  wire logic                           coil_action_complete_strobe,
  output logic      [mgctl_pkg::CTRL_BITS-1:0] ctrl_bits,
  output logic                                measure_start,
  output logic                                coil_set_start,
  output logic                                coil_reset_start,
  output logic                                analog_power_en,
  output logic                                data_ready
);
  import mgctl_pkg::*;

  typedef struct packed {
    logic [CTRL_BITS-1:0] ctrl;
    logic                 coil_seen;
    logic                 meas_go;
    logic                 set_go;
    logic                 reset_go;
    logic                 power_en;
    logic                 ready;
  } mgctl_coil_t;

  mgctl_coil_t c_ff;
  mgctl_coil_t nxt_c;
  logic        coil_busy;

  assign coil_busy = c_ff.ctrl[CTRL_SET_POS] | c_ff.ctrl[CTRL_RESET_POS];

  always_comb begin
    nxt_c          = c_ff;
    nxt_c.meas_go  = 1'b0;
    nxt_c.set_go   = 1'b0;
    nxt_c.reset_go = 1'b0;
    nxt_c.ready    = 1'b0;
    if (measure_complete_strobe && c_ff.ctrl[CTRL_MEAS_POS]) begin
      nxt_c.ctrl[CTRL_MEAS_POS] = 1'b0;
      nxt_c.ready               = 1'b1;
    end
    if (coil_action_complete_strobe) begin
      nxt_c.ctrl[CTRL_SET_POS]   = 1'b0;
      nxt_c.ctrl[CTRL_RESET_POS] = 1'b0;
    end
    // Writes after the clears, so a new measure request beats a same-cycle strobe
    if (ctrl_wr) begin
      if (ctrl_wdata[CTRL_MEAS_POS]) begin
        nxt_c.ctrl[CTRL_MEAS_POS] = 1'b1;
        nxt_c.meas_go             = !c_ff.ctrl[CTRL_MEAS_POS];
        nxt_c.ready               = 1'b0;
      end
      // Set outranks reset when both are written
      if (ctrl_wdata[CTRL_SET_POS] && !coil_busy) begin
        nxt_c.ctrl[CTRL_SET_POS] = 1'b1;
        nxt_c.set_go             = 1'b1;
        nxt_c.coil_seen          = 1'b1;
      end else if (ctrl_wdata[CTRL_RESET_POS] && !ctrl_wdata[CTRL_SET_POS] && !coil_busy
                   && !(low_voltage && !c_ff.coil_seen)) begin
        nxt_c.ctrl[CTRL_RESET_POS] = 1'b1;
        nxt_c.reset_go             = 1'b1;
        nxt_c.coil_seen            = 1'b1;
      end
    end
    nxt_c.power_en = |nxt_c.ctrl;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      c_ff <= '0;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign ctrl_bits        = c_ff.ctrl;
  assign measure_start    = c_ff.meas_go;
  assign coil_set_start   = c_ff.set_go;
  assign coil_reset_start = c_ff.reset_go;
  assign analog_power_en  = c_ff.power_en;
  assign data_ready       = c_ff.ready;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_meas_start: assert property (ctrl_wr && ctrl_wdata[0] && !c_ff.ctrl[0]
      |=> measure_start && ctrl_bits[0] ##1 !measure_start)
    else $error("measure start missing after write");
  a_meas_clear: assert property (measure_complete_strobe && c_ff.ctrl[0] && !(ctrl_wr && ctrl_wdata[0])
      |=> !ctrl_bits[0] && data_ready)
    else $error("measure bit did not clear on completion");
  a_set_priority: assert property (ctrl_wr && ctrl_wdata[1] && ctrl_wdata[2] && !coil_busy
      |=> coil_set_start && !coil_reset_start && !ctrl_bits[2])
    else $error("reset acted together with set");
  a_lv_first_reset: assert property (ctrl_wr && ctrl_wdata[2:1] == 2'h2 && low_voltage
      && !c_ff.coil_seen |=> !coil_reset_start && !ctrl_bits[2])
    else $error("first low-voltage reset was not ignored");
  a_coil_sleep: assert property (coil_action_complete_strobe && !ctrl_wr && !c_ff.ctrl[0]
      |=> ctrl_bits == CTRL_RST && !analog_power_en)
    else $error("coil bits or power stayed on after completion");
  c_set_done: cover property (coil_set_start ##[1:50] !analog_power_en);
  c_meas_done: cover property (measure_start ##[1:50] data_ready);

endmodule

// ===== hw/mgctl_pkg.sv
package mgctl_pkg;

  // Seven-bit address is 0110xx0; xx comes from the factory parameter of the top
  localparam logic [3:0] ADDR_FIXED_HI = 4'h6;
  localparam logic       ADDR_FIXED_LO = 1'h0;
  localparam logic [1:0] FACTORY_BITS_RST = 2'h0;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_X_HIGH = 8'h01;
  localparam logic [7:0] REG_X_LOW  = 8'h02;
  localparam logic [7:0] REG_Y_HIGH = 8'h03;
  localparam logic [7:0] REG_Y_LOW  = 8'h04;
  localparam logic [7:0] PTR_RST    = 8'h00;

  localparam int         CTRL_MEAS_POS  = 0;
  localparam int         CTRL_SET_POS   = 1;
  localparam int         CTRL_RESET_POS = 2;
  localparam int         CTRL_BITS      = 3;
  localparam logic [2:0] CTRL_RST       = 3'h0;

  localparam int         AXIS_BITS = 12;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Gray codes along address, ack, write and read paths
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE  = 3'h2,
    ST_WR_ACK   = 3'h6,
    ST_RD_BYTE  = 3'h7,
    ST_RD_ACK   = 3'h5
  } mgctl_state_t;

endpackage

// ===== hw/mgctl_sync.sv
module mgctl_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  import mgctl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } mgctl_sync_t;

  mgctl_sync_t sync_ff;
  mgctl_sync_t nxt_sync;

  // First stage feeds only the second stage
  always_comb begin
    nxt_sync.stage1 = async_i;
    nxt_sync.stage2 = sync_ff.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_ff <= {RST_VAL, RST_VAL};
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff.stage2;

endmodule

// ===== hw/mgctl_top.sv
module mgctl_top #(
  parameter logic [1:0] FACTORY_BITS = mgctl_pkg::FACTORY_BITS_RST
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe,
  input  wire logic                            low_voltage_i,
  input  wire logic                            measure_complete_strobe,
  input  wire logic                            coil_action_complete_strobe,
  input  wire logic [mgctl_pkg::AXIS_BITS-1:0] x_axis_data,
  input  wire logic [mgctl_pkg::AXIS_BITS-1:0] y_axis_data,
  output logic                                 measure_start,
  output logic                                 coil_set_start,
  output logic                                 coil_reset_start,
  output logic                                 analog_power_en,
  output logic                                 data_ready
);
  import mgctl_pkg::*;

  typedef struct packed {
    mgctl_state_t         state;
    logic [3:0]           bit_cnt;
    logic [7:0]           shreg;
    logic [7:0]           ptr;
    logic                 rd_dir;
    logic                 first_wr;
    logic                 master_ack;
    logic                 drive_low;
    logic                 scl_q;
    logic                 sda_q;
    logic [AXIS_BITS-1:0] x_hold;
    logic [AXIS_BITS-1:0] y_hold;
    logic                 ctrl_wr;
    logic [7:0]           wdata;
  } mgctl_top_t;

  mgctl_top_t           s_ff;
  mgctl_top_t           nxt_s;
  logic [2:0]           pins_sync;
  logic                 scl_s;
  logic                 sda_s;
  logic                 lv_s;
  logic [CTRL_BITS-1:0] ctrl_bits;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 bus_start;
  logic                 bus_stop;
  logic [6:0]           dev_addr;
  logic [7:0]           rd_byte;
  logic [7:0]           rd_next;

  mgctl_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h3)
  ) i_mgctl_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .async_i ({low_voltage_i, scl_i, sda_i}),
    .sync_o  (pins_sync)
  );

  assign lv_s  = pins_sync[2];
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  mgctl_coil i_mgctl_coil (
    .clk_sys                     (clk_sys),
    .rst_n                       (rst_n),
    .ctrl_wr                     (s_ff.ctrl_wr),
    .ctrl_wdata                  (s_ff.wdata),
    .low_voltage                 (lv_s),
    .measure_complete_strobe     (measure_complete_strobe),
    .coil_action_complete_strobe (coil_action_complete_strobe),
    .ctrl_bits                   (ctrl_bits),
    .measure_start               (measure_start),
    .coil_set_start              (coil_set_start),
    .coil_reset_start            (coil_reset_start),
    .analog_power_en             (analog_power_en),
    .data_ready                  (data_ready)
  );

  assign dev_addr  = {ADDR_FIXED_HI, FACTORY_BITS, ADDR_FIXED_LO};
  assign scl_rise  = scl_s && !s_ff.scl_q;
  assign scl_fall  = !scl_s && s_ff.scl_q;
  assign bus_start = scl_s && s_ff.scl_q && s_ff.sda_q && !sda_s;
  assign bus_stop  = scl_s && s_ff.scl_q && !s_ff.sda_q && sda_s;

  // Read map; high axis nibbles and unused control bits read zero
  function automatic logic [7:0] map_read(input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    case (p)
      REG_CTRL:   v = {5'h00, ctrl_bits};
      REG_X_HIGH: v = {4'h0, s_ff.x_hold[11:8]};
      REG_X_LOW:  v = s_ff.x_hold[7:0];
      REG_Y_HIGH: v = {4'h0, s_ff.y_hold[11:8]};
      REG_Y_LOW:  v = s_ff.y_hold[7:0];
      default:    v = 8'h00;
    endcase
    return v;
  endfunction

  // A process, not an assign: control and result changes must retrigger the map
  always_comb begin
    rd_byte = map_read(s_ff.ptr);
    rd_next = map_read(s_ff.ptr);
  end

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.ctrl_wr = 1'b0;
    nxt_s.scl_q   = scl_s;
    nxt_s.sda_q   = sda_s;
    // Results held here so sleep never loses them
    if (measure_complete_strobe) begin
      nxt_s.x_hold = x_axis_data;
      nxt_s.y_hold = y_axis_data;
    end
    if (bus_start) begin
      nxt_s.state     = ST_ADDR;
      nxt_s.bit_cnt   = 4'h0;
      nxt_s.drive_low = 1'b0;
    end else if (bus_stop) begin
      nxt_s.state     = ST_IDLE;
      nxt_s.drive_low = 1'b0;
    end else begin
      case (s_ff.state)
        ST_IDLE: begin
          nxt_s.drive_low = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise && s_ff.bit_cnt < BYTE_BITS) begin
            nxt_s.shreg   = {s_ff.shreg[6:0], sda_s};
            nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
          end
          if (scl_fall && s_ff.bit_cnt == BYTE_BITS) begin
            if (s_ff.shreg[7:1] == dev_addr) begin
              nxt_s.state     = ST_ADDR_ACK;
              nxt_s.drive_low = 1'b1;
              nxt_s.rd_dir    = s_ff.shreg[0];
              nxt_s.first_wr  = 1'b1;
            end else begin
              nxt_s.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_ff.rd_dir) begin
              nxt_s.state     = ST_RD_BYTE;
              nxt_s.drive_low = !rd_byte[7];
              nxt_s.shreg     = {rd_byte[6:0], 1'b0};
              nxt_s.bit_cnt   = 4'h1;
            end else begin
              nxt_s.state     = ST_WR_BYTE;
              nxt_s.drive_low = 1'b0;
              nxt_s.bit_cnt   = 4'h0;
            end
          end
        end
        ST_WR_BYTE: begin
          if (scl_rise && s_ff.bit_cnt < BYTE_BITS) begin
            nxt_s.shreg   = {s_ff.shreg[6:0], sda_s};
            nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
          end
          if (scl_fall && s_ff.bit_cnt == BYTE_BITS) begin
            nxt_s.state     = ST_WR_ACK;
            nxt_s.drive_low = 1'b1;
            if (s_ff.first_wr) begin
              nxt_s.ptr      = s_ff.shreg;
              nxt_s.first_wr = 1'b0;
            end else if (s_ff.ptr == REG_CTRL) begin
              nxt_s.ctrl_wr = 1'b1;
              nxt_s.wdata   = s_ff.shreg;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            nxt_s.state     = ST_WR_BYTE;
            nxt_s.drive_low = 1'b0;
            nxt_s.bit_cnt   = 4'h0;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (s_ff.bit_cnt == BYTE_BITS) begin
              nxt_s.state     = ST_RD_ACK;
              nxt_s.drive_low = 1'b0;
              nxt_s.ptr       = s_ff.ptr + 8'h01;
            end else begin
              nxt_s.drive_low = !s_ff.shreg[7];
              nxt_s.shreg     = {s_ff.shreg[6:0], 1'b0};
              nxt_s.bit_cnt   = s_ff.bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nxt_s.master_ack = !sda_s;
          end
          if (scl_fall) begin
            // Missing acknowledge ends the read; release and go idle until the next start
            if (s_ff.master_ack) begin
              nxt_s.state     = ST_RD_BYTE;
              nxt_s.drive_low = !rd_next[7];
              nxt_s.shreg     = {rd_next[6:0], 1'b0};
              nxt_s.bit_cnt   = 4'h1;
            end else begin
              nxt_s.state = ST_IDLE;
            end
          end
        end
        default: begin
          nxt_s.state     = ST_IDLE;
          nxt_s.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_ff       <= '0;
      s_ff.state <= ST_IDLE;
      s_ff.ptr   <= PTR_RST;
      s_ff.scl_q <= 1'b1;
      s_ff.sda_q <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Open drain: the line is only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = s_ff.drive_low;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_addr_match: assert property (s_ff.state == ST_ADDR && !bus_start && !bus_stop && scl_fall
      && s_ff.bit_cnt == BYTE_BITS && s_ff.shreg[7:1] == dev_addr
      |=> s_ff.state == ST_ADDR_ACK && sda_oe)
    else $error("matching address not acknowledged");
  a_addr_other: assert property (s_ff.state == ST_ADDR && !bus_start && !bus_stop && scl_fall
      && s_ff.bit_cnt == BYTE_BITS && s_ff.shreg[7:1] != dev_addr
      |=> s_ff.state == ST_IDLE && !sda_oe)
    else $error("foreign address answered");
  a_wr_ack: assert property (s_ff.state == ST_WR_BYTE && !bus_start && !bus_stop && scl_fall
      && s_ff.bit_cnt == BYTE_BITS |=> sda_oe && s_ff.state == ST_WR_ACK)
    else $error("written byte not acknowledged");
  a_ptr_advance: assert property (s_ff.state == ST_RD_BYTE && !bus_start && !bus_stop
      && scl_fall && s_ff.bit_cnt == BYTE_BITS
      |=> s_ff.ptr == $past(s_ff.ptr) + 8'h01 && !sda_oe)
    else $error("pointer did not advance after read byte");
  a_rd_msb: assert property (s_ff.state == ST_ADDR_ACK && s_ff.rd_dir && !bus_start && !bus_stop
      && scl_fall |=> sda_oe == !$past(rd_byte[7]))
    else $error("read byte did not start with its top bit");
  a_ptr_write: assert property (s_ff.state == ST_WR_BYTE && s_ff.first_wr && !bus_start
      && !bus_stop && scl_fall && s_ff.bit_cnt == BYTE_BITS
      |=> s_ff.ptr == $past(s_ff.shreg) && !s_ff.ctrl_wr)
    else $error("first written byte not taken as pointer");
  a_map_zero: assert property (s_ff.ptr > REG_Y_LOW || s_ff.ptr == REG_X_HIGH
      || s_ff.ptr == REG_Y_HIGH |-> rd_byte[7:4] == 4'h0)
    else $error("unused read bits not zero");
  a_rst_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
      !rst_n |=> s_ff.ptr == PTR_RST && ctrl_bits == CTRL_RST && !sda_oe)
    else $error("reset did not clear pointer and control");
  c_addr_ack: cover property (s_ff.state == ST_ADDR_ACK);
  c_five_bytes: cover property (s_ff.state == ST_RD_ACK && s_ff.ptr == 8'h05);
  c_ctrl_write: cover property (s_ff.ctrl_wr && s_ff.wdata == 8'h01);

endmodule

// ===== tb/mgctl_i2c_master.sv
module mgctl_i2c_master #(
  parameter int HALF = 10
) (
  input  wire logic clk_sys,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Also a repeated start, entered from the ack bit's low phase
  task automatic start();
    sda_pull <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_pull <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_pull <= 1'b0;
    wait_clk(2 * HALF);
  endtask

  // Data only moves mid low phase, never near an SCL edge
  task automatic xfer_bit(input logic b, output logic r);
    sda_pull <= ~b;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    r = sda_in;
    scl <= 1'b0;
    wait_clk(HALF);
  endtask

  // Releasing the line (1) lets the far end drive data or ack
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
      q[i] = r;
    end
    xfer_bit(ack_in, ack_out);
  endtask
endmodule

// ===== tb/tb_mgctl_top.sv
module tb_mgctl_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mgctl_pkg::*;

  localparam logic [1:0] FB    = 2'h2;
  localparam logic [7:0] DEV_W = {ADDR_FIXED_HI, FB, ADDR_FIXED_LO, 1'b0};

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl, sda_pull, sda, sda_o, sda_oe, lv = 1'b0;
  logic        meas_stb = 1'b0;
  logic        coil_stb = 1'b0;
  logic [11:0] x_data = 12'h000;
  logic [11:0] y_data = 12'h000;
  logic        m_start, c_set, c_rst, pwr_en, d_rdy;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_ms = 0, n_cs = 0, n_cr = 0, n_dr = 0;

  always #20 clk_sys = ~clk_sys;
  // Open-drain wire with pull-up
  assign sda = ~((sda_oe & ~sda_o) | sda_pull);

  mgctl_top #(.FACTORY_BITS(FB)) i_mgctl_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .low_voltage_i(lv), .measure_complete_strobe(meas_stb),
    .coil_action_complete_strobe(coil_stb), .x_axis_data(x_data),
    .y_axis_data(y_data), .measure_start(m_start), .coil_set_start(c_set),
    .coil_reset_start(c_rst), .analog_power_en(pwr_en), .data_ready(d_rdy));

  mgctl_i2c_master i_m (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_pull(sda_pull));

  always @(posedge clk_sys) begin
    if (m_start === 1'b1) n_ms++;
    if (c_set === 1'b1) n_cs++;
    if (c_rst === 1'b1) n_cr++;
    if (d_rdy === 1'b1) n_dr++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    i_m.start();
    i_m.xfer_byte(DEV_W, 1'b1, q, a);
    check({7'h0, a}, 8'h00);
    i_m.xfer_byte(ptr, 1'b1, q, a);
    check({7'h0, a}, 8'h00);
    i_m.xfer_byte(d, 1'b1, q, a);
    check({7'h0, a}, 8'h00);
    i_m.stop();
  endtask

  task automatic reg_read(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic [7:0] q;
    logic       a;
    i_m.start();
    i_m.xfer_byte(DEV_W, 1'b1, q, a);
    check({7'h0, a}, 8'h00);
    i_m.xfer_byte(ptr, 1'b1, q, a);
    i_m.start();
    i_m.xfer_byte(DEV_W | 8'h01, 1'b1, q, a);
    check({7'h0, a}, 8'h00);
    foreach (exp[i]) begin
      i_m.xfer_byte(8'hFF, i == exp.size() - 1, q, a);
      check(q, exp[i]);
    end
    i_m.stop();
  endtask

  task automatic probe_addr(input logic [7:0] addr);
    logic [7:0] q;
    logic       a;
    i_m.start();
    i_m.xfer_byte(addr, 1'b1, q, a);
    check({7'h0, a}, 8'h01);
    i_m.stop();
  endtask

  task automatic pulse_done(input logic meas, input logic [11:0] x, input logic [11:0] y);
    @(posedge clk_sys);
    x_data   <= x;
    y_data   <= y;
    meas_stb <= meas;
    coil_stb <= ~meas;
    @(posedge clk_sys);
    meas_stb <= 1'b0;
    coil_stb <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end

  initial begin
    do_reset();
    check({7'h0, pwr_en}, 8'h00);
    reg_read(8'h00, {8'h00});
    for (int f = 0; f < 4; f++) begin
      if (f[1:0] != FB) probe_addr({ADDR_FIXED_HI, f[1:0], ADDR_FIXED_LO, 1'b0});
    end
    $display("Test done: reset and address");
    reg_write(8'h00, 8'h01);
    check(8'(n_ms), 8'h01);
    check({7'h0, pwr_en}, 8'h01);
    reg_read(8'h00, {8'h01});
    pulse_done(1'b1, 12'hFBC, 12'h823);
    check(8'(n_dr), 8'h01);
    check({7'h0, pwr_en}, 8'h00);
    reg_read(8'h00, {8'h00, 8'h0F, 8'hBC, 8'h08, 8'h23, 8'h00});
    reg_read(8'h03, {8'h08, 8'h23});
    reg_write(8'h02, 8'h01);
    check(8'(n_ms), 8'h01);
    $display("Test done: measurement");
    reg_write(8'h00, 8'hF6);
    check(8'(n_cs), 8'h01);
    check(8'(n_cr), 8'h00);
    reg_read(8'h00, {8'h02});
    pulse_done(1'b0, 12'hFBC, 12'h823);
    reg_read(8'h00, {8'h00});
    reg_write(8'h00, 8'h04);
    check(8'(n_cr), 8'h01);
    pulse_done(1'b0, 12'hFBC, 12'h823);
    check({7'h0, pwr_en}, 8'h00);
    $display("Test done: coil");
    lv <= 1'b1;
    do_reset();
    reg_write(8'h00, 8'h04);
    check(8'(n_cr), 8'h01);
    reg_read(8'h00, {8'h00});
    reg_write(8'h00, 8'h02);
    check(8'(n_cs), 8'h02);
    pulse_done(1'b0, 12'h000, 12'h000);
    reg_write(8'h00, 8'h04);
    check(8'(n_cr), 8'h02);
    $display("Test done: low voltage");
    print_verdict();
  end
endmodule
